// >>> rtl/adc_readout_cfg.svh
/*
 * Constants for the two-channel serial converter readout.
 * Assumes a 200 MHz ref_clk; the serial link pins are asynchronous to it.
 */
// Summary of operation
// [RULE_01] A readout frame spans exactly sixteen serial clock cycles.
// [RULE_02] The first four bits of every frame are zero on both data lines.
// [RULE_03] The twelve result bits follow, most significant bit first.
// [RULE_04] The first leading zero appears when chip select falls, before any serial clock edge.
// [RULE_05] Every later bit is advanced on a falling serial clock edge.
// [RULE_06] Both data lines are outputs of the device only, one per channel.
// [RULE_07] The host starts frames no faster than one million per second; both channels convert together.
// [RULE_08] The host samples on rising serial clock and raises chip select after the sixteenth cycle.
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH
`define FRAME_BITS 16
`define LEAD_ZEROS 4
`define RESULT_BITS 12
`define FIFO_DEPTH 32
`define MIN_FRAME_NS 1000
`define CLK_PERIOD_NS 5
`endif

// >>> rtl/adc_readout_pkg.sv
/*
 * Types for the converter readout.
 * Assumes the config header is included by the user.
 */
package adc_readout_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b10
    } frame_state_t;
endpackage

// >>> rtl/adc_readout.sv
/*
 * Sample FIFO and device-side serial readout of two converter channels.
 * Assumes cs and serial clock come from the host; sample pairs arrive from
 * converter logic on ref_clk.
 */
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"

// ==========================================
// sample fifo
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic doWrite, doRead;
    assign inReady = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr_reg[AW-1:0]];
    always_comb begin
        wrPtr_next = wrPtr_reg + (AW+1)'(doWrite);
        rdPtr_next = rdPtr_reg + (AW+1)'(doRead);
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
endmodule // sample_fifo

// ==========================================
// serial readout
module adc_readout import adc_readout_pkg::*; #(
    parameter int RES = `RESULT_BITS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [RES-1:0] sampleA,
    input wire logic [RES-1:0] sampleB,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire logic csN,
    input wire logic serialClk,
    output logic first_channel_serial_out,
    output logic second_channel_serial_out,
    output logic frameActive
);
    localparam int W = 2 * RES;
    logic [W-1:0] fifoData;
    logic fifoValid, fifoReady;
    sample_fifo #(.WIDTH(W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .inData({sampleA, sampleB}), .inValid(sampleValid), .inReady(sampleReady),
        .outData(fifoData), .outValid(fifoValid), .outReady(fifoReady)
    );

    // two-flop synchronisers; only stage two feeds logic
    logic [1:0] csSync_reg, csSync_next, sckSync_reg, sckSync_next;
    logic csLast_reg, csLast_next, sckLast_reg, sckLast_next;
    always_comb begin
        csSync_next = {csSync_reg[0], csN};
        sckSync_next = {sckSync_reg[0], serialClk};
        csLast_next = csSync_reg[1];
        sckLast_next = sckSync_reg[1];
    end
    // reset values match idle pins so no false edge follows reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            csSync_reg <= 2'h3;
            sckSync_reg <= 2'h0;
            csLast_reg <= 1'b1;
            sckLast_reg <= 1'b0;
        end else begin
            csSync_reg <= csSync_next;
            sckSync_reg <= sckSync_next;
            csLast_reg <= csLast_next;
            sckLast_reg <= sckLast_next;
        end
    end
    logic csFall, csRise, sckFall;
    assign csFall = csLast_reg && !csSync_reg[1];
    assign csRise = !csLast_reg && csSync_reg[1];
    assign sckFall = sckLast_reg && !sckSync_reg[1] && !csSync_reg[1];

    // ==========================================
    // frame shifter
    frame_state_t state_reg, state_next;
    logic [`FRAME_BITS-1:0] shA_reg, shA_next, shB_reg, shB_next;
    logic [4:0] bitCnt_reg, bitCnt_next;
    logic [RES-1:0] holdA_reg, holdA_next, holdB_reg, holdB_next;
    assign fifoReady = (state_reg == ST_IDLE) && csFall;
    always_comb begin
        state_next = state_reg;
        shA_next = shA_reg;
        shB_next = shB_reg;
        bitCnt_next = bitCnt_reg;
        holdA_next = holdA_reg;
        holdB_next = holdB_reg;
        case (state_reg)
            ST_IDLE: begin
                if (csFall) begin
                    // empty fifo repeats last pair rather than stalling the host
                    if (fifoValid) begin
                        holdA_next = fifoData[W-1:RES];
                        holdB_next = fifoData[RES-1:0];
                        shA_next = {4'h0, fifoData[W-1:RES]}; // RULE_02 RULE_03 RULE_07
                        shB_next = {4'h0, fifoData[RES-1:0]};
                    end else begin
                        shA_next = {4'h0, holdA_reg}; // RULE_02
                        shB_next = {4'h0, holdB_reg};
                    end
                    bitCnt_next = 5'h01; // RULE_04
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (csRise) begin
                    state_next = ST_IDLE;
                end else if (sckFall) begin
                    shA_next = {shA_reg[`FRAME_BITS-2:0], 1'b0}; // RULE_05
                    shB_next = {shB_reg[`FRAME_BITS-2:0], 1'b0};
                    bitCnt_next = bitCnt_reg + 5'h01;
                    if (bitCnt_reg == 5'(`FRAME_BITS)) begin
                        state_next = ST_DONE; // RULE_01
                    end
                end
            end
            ST_DONE: begin
                if (csRise) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            shA_reg <= '0;
            shB_reg <= '0;
            bitCnt_reg <= 5'h00;
            holdA_reg <= '0;
            holdB_reg <= '0;
        end else begin
            state_reg <= state_next;
            shA_reg <= shA_next;
            shB_reg <= shB_next;
            bitCnt_reg <= bitCnt_next;
            holdA_reg <= holdA_next;
            holdB_reg <= holdB_next;
        end
    end
    // outputs only, never inputs
    always_comb begin
        first_channel_serial_out = shA_reg[`FRAME_BITS-1]; // RULE_06
        second_channel_serial_out = shB_reg[`FRAME_BITS-1];
        frameActive = state_reg != ST_IDLE;
    end

    // ==========================================
    // assertions
    property p_lead_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && csFall) |=> (first_channel_serial_out == 1'b0 && second_channel_serial_out == 1'b0);
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("first bit not zero"); // RULE_04
    property p_zero_head;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT && bitCnt_reg <= 5'h04) |-> (shA_reg[15] == 1'b0 && shB_reg[15] == 1'b0);
    endproperty
    a_zero_head: assert property (p_zero_head) else $error("leading zero missing"); // RULE_02
    property p_msb_first;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT && bitCnt_reg == 5'h04 && sckFall && !csRise)
        |=> (first_channel_serial_out == holdA_reg[RES-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not first"); // RULE_03
    property p_shift_on_fall;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT && !sckFall && !csRise) |=> $stable(shA_reg);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("shift off edge"); // RULE_05
    property p_sixteen;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT && sckFall && !csRise && bitCnt_reg == 5'h10) |=> state_reg == ST_DONE;
    endproperty
    a_sixteen: assert property (p_sixteen) else $error("frame length wrong"); // RULE_01
    property p_both_lines;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && csFall && fifoValid)
        |=> (shA_reg == {4'h0, $past(fifoData[W-1:RES])} && shB_reg == {4'h0, $past(fifoData[RES-1:0])});
    endproperty
    a_both_lines: assert property (p_both_lines) else $error("channel pair split"); // RULE_06
    property p_done_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == ST_DONE) |-> (shA_reg == '0 && first_channel_serial_out == 1'b0);
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("data after frame"); // RULE_01
    property p_pop_once;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoReady && fifoValid) |=> !fifoReady;
    endproperty
    a_pop_once: assert property (p_pop_once) else $error("double pop"); // RULE_07
    c_frame: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == ST_SHIFT ##1 state_reg == ST_DONE);
    c_abort: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == ST_SHIFT && csRise);
    c_full: cover property (@(posedge ref_clk) disable iff (!rst_n) !sampleReady);
    c_empty_frame: cover property (@(posedge ref_clk) disable iff (!rst_n) csFall && !fifoValid);
endmodule // adc_readout

// >>> bench/host_model.sv
/* host board model: drives chip select and serial clock, shifts in both lines.
   assumes the device's data lines are driven by the device only. */
`timescale 1ns/1ps
// ==========
// host model
module host_model #(
    parameter int FRAME_NS = 1000
) (
    output logic csN,
    output logic serialClk,
    input wire logic firstLine,
    input wire logic secondLine,
    output logic [15:0] capA,
    output logic [15:0] capB
);
    initial begin
        csN = 1'b1;
        serialClk = 1'b0; // clock still between frames
        capA = '0;
        capB = '0;
    end
    // fewer than 16 bits means an aborted frame
    task automatic frame(input int nBits);
        realtime t0;
        t0 = $realtime;
        csN = 1'b0;
        #48;
        for (int i = 0; i < nBits; i++) begin
            serialClk = 1'b1;
            capA = {capA[14:0], firstLine};
            capB = {capB[14:0], secondLine};
            #24;
            serialClk = 1'b0;
            #24;
        end
        csN = 1'b1;
        #200;
        // short aborted frames would otherwise start again too soon
        if ($realtime - t0 < FRAME_NS) begin
            #(FRAME_NS - ($realtime - t0));
        end
    endtask
endmodule // host_model

// >>> bench/testbench.sv
/* self-checking bench for the two-channel serial readout.
   assumes host_model on the link pins and 200 MHz ref_clk. */
`timescale 1ns/1ps
// ==========
// bench top
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] sampleA = '0;
    logic [11:0] sampleB = '0;
    logic sampleValid = 1'b0;
    logic sampleReady, csN, serialClk, lineA, lineB, frameActive;
    logic [15:0] capA, capB;
    int failures = 0;
    int nChecks = 0;
    int cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    adc_readout u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sampleA(sampleA), .sampleB(sampleB),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .csN(csN), .serialClk(serialClk),
        .first_channel_serial_out(lineA), .second_channel_serial_out(lineB), .frameActive(frameActive));
    host_model u_host (.csN(csN), .serialClk(serialClk), .firstLine(lineA), .secondLine(lineB),
        .capA(capA), .capB(capB));
    function automatic logic [11:0] valA(input int i);
        return (i == 31) ? 12'hFFF : 12'(i * 131);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic reset_state();
        check({lineA, lineB, frameActive, sampleReady}, 16'h0001);
    endtask
    // far side stalls while the fifo fills, then a refused push
    task automatic fill_fifo();
        for (int i = 0; i < 32; i++) begin
            sampleA <= valA(i);
            sampleB <= ~valA(i);
            sampleValid <= 1'b1;
            @(posedge ref_clk);
        end
        sampleA <= 12'h5A5;
        repeat (3) @(posedge ref_clk);
        sampleValid <= 1'b0;
        #1 check(sampleReady, 16'h0000);
    endtask
    task automatic drain_fifo();
        for (int i = 0; i < 32; i++) begin
            u_host.frame(16);
            check(capA, {4'h0, valA(i)});
            check(capB, {4'h0, ~valA(i)});
        end
        check(frameActive, 16'h0000);
        check(sampleReady, 16'h0001);
        u_host.frame(16);
        check(capA, 16'h0FFF);
    endtask
    task automatic abort_frame();
        u_host.frame(6);
        check(capA[5:0], 6'h03);
        check(frameActive, 16'h0000);
        u_host.frame(16);
        check(capB, 16'h0000);
        check(capA, 16'h0FFF);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1 reset_state();
        @(posedge ref_clk);
        fill_fifo();
        drain_fifo();
        abort_frame();
        complete_run();
    end
endmodule // testbench
